// file: verification/spcl_far_end.sv
`timescale 1ns/10ps
module spcl_far_end
(
  input  wire logic       aclk,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_capture_phase,
  input  wire logic       hold_sel,
  input  wire logic [7:0] s_tx,
  input  wire logic       sck_o,
  input  wire logic       sck_oe,
  input  wire logic       mosi_o,
  input  wire logic       miso_o,
  output logic            sck_i,
  output logic            mosi_i,
  output logic            miso_i,
  output logic            ss_n_i,
  output logic [7:0]      s_rx
);
  logic       sck_q = 1'b0;
  logic       ss_r = 1'b1;
  logic [4:0] edge_n = 5'h0;
  logic [2:0] bit_n;
  initial sck_i = 1'b0;
  initial mosi_i = 1'b0;
  initial s_rx = 8'h0;
  // ==========================================================
  // Select pin, pulled high unless this far end drives it
  assign ss_n_i = ss_r & ~hold_sel;
  // ==========================================================
  // Slave facing the design as controller
  always_comb bit_n = clock_capture_phase ? 3'((edge_n - 5'h1) >> 1) : 3'(edge_n >> 1);
  // Off-frame the line shows the inverse, never a stale good bit
  assign miso_i = s_tx[3'h7 - bit_n] ^ ~sck_oe;
  always @(posedge aclk)
  begin
    sck_q <= sck_o;
    if (!sck_oe)
      edge_n <= 5'h0;
    else if (sck_o != sck_q)
    begin
      edge_n <= (edge_n == 5'hf) ? 5'h0 : edge_n + 5'h1;
      if (edge_n[0] == clock_capture_phase)
        s_rx <= {s_rx[6:0], mosi_o};
    end
  end
  // ==========================================================
  // Controller facing the design as slave, half period of 4 cycles
  task automatic mxfer(input logic [7:0] tx, output logic [7:0] rx);
    int e;
    rx = 8'h0;
    @(posedge aclk);
    ss_r <= 1'b0;
    sck_i <= clock_idle_level;
    mosi_i <= tx[7];
    for (e = 1; e <= 16; e++)
    begin
      repeat (4) @(posedge aclk);
      sck_i <= ~sck_i;
      if (e[0] != clock_capture_phase)
        rx = {rx[6:0], miso_o};
      if (e[0] == clock_capture_phase && e < 16)
        mosi_i <= tx[7 - ((e - clock_capture_phase) >> 1)];
    end
    repeat (8) @(posedge aclk);
    ss_r <= 1'b1;
    mosi_i <= ~mosi_i;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// file: verification/spi_ctrl_lowpower_irq_bench.sv
`timescale 1ns/10ps
`include "spcl_defs.svh"
module spi_ctrl_lowpower_irq_bench;
  import spcl_pkg::*;
  localparam logic [11:0] A_DATA = {2'h0, `SPCL_IDX_DATA, 2'h0};
  localparam logic [11:0] A_CTRL = {2'h0, `SPCL_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, `SPCL_IDX_STAT, 2'h0};
  logic aclk = 1'b0, aresetn = 1'b0, halt_i = 1'b0, cpu_imask_i = 1'b0, hold_sel = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Response readies held high: this master never stalls an answer
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, clock_idle_level = 1'b0, clock_capture_phase = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [7:0]  s_tx = 8'h0, s_rx, tx, rx;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, ss_n_i;
  logic irq_o, wake_wait_o, wake_halt_o, sck_q = 1'b0;
  logic [6:0]  run_n = 7'h0, half_seen;
  logic [65:0] notes[$];
  logic [65:0] note;
  spcl_resp_type s_axi_bresp, s_axi_rresp;
  int failures = 0, samples_checked = 0;
  logic [2:0] codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
  logic [6:0] halves [6] = '{`SPCL_HALF_4, `SPCL_HALF_8, `SPCL_HALF_16,
                             `SPCL_HALF_32, `SPCL_HALF_64, `SPCL_HALF_128};
  always #50 aclk = ~aclk;
  spcl_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o,
    .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .halt_i, .cpu_imask_i, .irq_o,
    .wake_wait_o, .wake_halt_o);
  spcl_far_end i_far (.aclk, .clock_idle_level, .clock_capture_phase, .hold_sel, .s_tx, .sck_o, .sck_oe, .mosi_o,
    .miso_o, .sck_i, .mosi_i, .miso_i, .ss_n_i, .s_rx);
  // ==========================================================
  // Checking and verdict
  task results;
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      note = notes.pop_front();
      check(s_axi_rdata & note[63:32], note[31:0]);
      check(32'(s_axi_rresp), 32'(note[65:64]));
    end
  // Serial clock half period, last interval between toggles
  always @(posedge aclk)
  begin
    sck_q <= sck_o;
    run_n <= (sck_o != sck_q) ? 7'h1 : run_n + 7'h1;
    if (sck_o != sck_q)
      half_seen <= run_n;
  end
  // ==========================================================
  // Register bus
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    check(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] er,
                    output logic [31:0] v);
    notes.push_back({er, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    v = s_axi_rdata;
  endtask
  task automatic wait_done;
    logic [31:0] v;
    v = 32'h0;
    while (!v[7]) rd(A_STAT, 32'h0, 32'h0, 2'h0, v);
  endtask
  // ==========================================================
  // Scenarios
  initial
  begin
    void'($urandom(92415));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_CTRL, 32'h0, 32'hff, 2'h0, d);
    rd(A_STAT, 32'h0, 32'hff, 2'h0, d);
    rd(12'h0f0, 32'h0, 32'hffffffff, `SPCL_RESP_ERR, d);
    wr(12'h0f0, 8'h00, `SPCL_RESP_ERR);
    for (int i = 0; i < 6; i++)
    begin
      clock_idle_level <= i[0];
      clock_capture_phase <= i[1];
      cpu_imask_i <= i[0];
      s_tx <= 8'($urandom);
      tx = 8'($urandom);
      wr(A_CTRL, {2'b10, codes[i][2], 1'b1, i[0], i[1], codes[i][1:0]}, 2'h0);
      @(posedge aclk);
      check(32'(sck_o), 32'(i[0]));
      wr(A_CTRL, {2'b11, codes[i][2], 1'b1, i[0], i[1], codes[i][1:0]}, 2'h0);
      wr(A_DATA, tx, 2'h0);
      wait_done;
      check(32'(half_seen), 32'(halves[i]));
      check(32'(s_rx), 32'(tx));
      check(32'({irq_o, wake_wait_o, wake_halt_o}), {29'h0, ~i[0], 2'b11});
      check(32'({sck_oe, mosi_oe, miso_oe}), 32'h6);
      rd(A_DATA, 32'(s_tx), 32'hff, 2'h0, d);
    end
    wr(A_CTRL, 8'h50, 2'h0);
    hold_sel <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(A_STAT, 32'h10, 32'h10, 2'h0, d);
    rd(A_CTRL, 32'h0, 32'h50, 2'h0, d);
    hold_sel <= 1'b0;
    wr(A_CTRL, 8'h00, 2'h0);
    rd(A_STAT, 32'h0, 32'h10, 2'h0, d);
    clock_idle_level <= 1'b0;
    clock_capture_phase <= 1'b0;
    wr(A_CTRL, 8'h40, 2'h0);
    d = $urandom;
    wr(A_DATA, d[7:0], 2'h0);
    tx = 8'($urandom);
    i_far.mxfer(tx, rx);
    check(32'(rx), 32'(d[7:0]));
    wr(A_DATA, ~tx, 2'h0);
    i_far.mxfer(~tx, rx);
    check(32'(rx), 32'(tx));
    rd(A_STAT, 32'ha0, 32'ha0, 2'h0, d);
    rd(A_DATA, 32'(tx), 32'hff, 2'h0, d);
    rd(A_STAT, 32'h0, 32'ha0, 2'h0, d);
    clock_capture_phase <= 1'b1;
    wr(A_STAT, 8'h02, 2'h0);
    wr(A_CTRL, 8'hc4, 2'h0);
    check(32'({sck_oe, mosi_oe, miso_oe}), 32'h1);
    halt_i <= 1'b1;
    tx = 8'($urandom);
    i_far.mxfer(tx, rx);
    check(32'(wake_halt_o), 32'h1);
    halt_i <= 1'b0;
    rd(A_DATA, 32'(tx), 32'hff, 2'h0, d);
    i_far.mxfer(~tx, rx);
    check(32'(rx), 32'(tx));
    rd(A_STAT, 32'ha0, 32'ha0, 2'h0, d);
    wr(A_STAT, 8'h06, 2'h0);
    @(posedge aclk);
    check(32'(miso_oe), 32'h0);
    results;
  end
  // Longest rate alone needs about 1100 cycles; ten times the whole run
  initial
  begin
    repeat (30000) @(posedge aclk);
    failures++;
    results;
  end
endmodule

// file: verilog/spcl_defs.svh
`ifndef SPCL_DEFS_SVH
`define SPCL_DEFS_SVH
// ==========================================================
// Register indices, byte address is four times the index
`define SPCL_IDX_DATA   8'h31
`define SPCL_IDX_CTRL   8'h32
`define SPCL_IDX_STAT   8'h33
// ==========================================================
// Reset values
`define SPCL_CTRL_RESET 8'h00
`define SPCL_STAT_RESET 8'h00
// ==========================================================
// Control register fields
`define SPCL_CTRL_IE    7
`define SPCL_CTRL_PE    6
`define SPCL_CTRL_D2    5
`define SPCL_CTRL_MS    4
`define SPCL_CTRL_POL   3
`define SPCL_CTRL_PHA   2
// ==========================================================
// Status register fields
`define SPCL_STAT_DONE  7
`define SPCL_STAT_WRITE_CLASH_FLAG  6
`define SPCL_STAT_OVR   5
`define SPCL_STAT_FLT   4
`define SPCL_STAT_SOD   2
`define SPCL_STAT_SSM   1
`define SPCL_STAT_SSI   0
// ==========================================================
// Serial timing: clock edges per byte, half periods per rate
`define SPCL_EDGES      5'h10
`define SPCL_HALF_4     7'h02
`define SPCL_HALF_8     7'h04
`define SPCL_HALF_16    7'h08
`define SPCL_HALF_32    7'h10
`define SPCL_HALF_64    7'h20
`define SPCL_HALF_128   7'h40
// ==========================================================
// Bus answers
`define SPCL_RESP_OKAY  2'h0
`define SPCL_RESP_ERR   2'h2
`endif

// file: verilog/spcl_pkg.sv
package spcl_pkg;
  typedef enum logic [0:0]
  {
    SPCL_IDLE = 1'b0,
    SPCL_XFER = 1'b1
  } spcl_state_type;
  typedef logic [1:0] spcl_resp_type;
  typedef enum logic [1:0]
  {
    SPCL_SEL_NONE = 2'b00,
    SPCL_SEL_DATA = 2'b01,
    SPCL_SEL_CTRL = 2'b10,
    SPCL_SEL_STAT = 2'b11
  } spcl_sel_type;
endpackage

// file: verilog/spcl_rate_div.sv
`timescale 1ns/10ps
`include "spcl_defs.svh"
module spcl_rate_div
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [6:0] half;
  logic [6:0] cnt_r;

  // ==========================================================
  // Half period per rate code (div2 control, rate select)
  always_comb
  begin
    unique case (sel)
      3'b100:  half = `SPCL_HALF_4;
      3'b000:  half = `SPCL_HALF_8;
      3'b001:  half = `SPCL_HALF_16;
      3'b110:  half = `SPCL_HALF_32;
      3'b010:  half = `SPCL_HALF_64;
      3'b011:  half = `SPCL_HALF_128;
      // Unlisted codes fall back: 101 to the /16 rate, 111 to the slowest rate
      3'b101:  half = `SPCL_HALF_16;
      default: half = `SPCL_HALF_128;
    endcase
  end

  // ==========================================================
  // Counter, one-cycle tick per half serial clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
      cnt_r <= 7'h00;
    else if (run)
      cnt_r <= (cnt_r == half - 7'h01) ? 7'h00 : cnt_r + 7'h01;
  end

  assign tick = run && !restart && (cnt_r == half - 7'h01);
endmodule

// file: verilog/spcl_top.sv
// Overview of operation
// - Idle slave echoes previously received byte back on its next transfer.
// - Wait mode leaves the port running; done, fault or overrun requests wait exit.
// - Halt freezes the port registers and logic until woken, except a slave selected at halt entry.
// - Second byte received before done flag cleared after halt sets overrun.
// - Slave completion raises done interrupt to end halt; byte stays readable.
// - Halt wake works only if effective select is low at halt entry.
// - Done, fault and overrun share one request, gated by enable and cpu mask.
// - Fault may end wait, never halt; done may end halt.
// - Control bit 7 enables the interrupt request.
// - Control bit 6 connects pins; cleared by reset and master fault.
// - Control bit 4 selects master; cleared on master fault.
// - Control bit 3 sets serial clock idle level in master mode only; the slave counts edges of either polarity.
// - Control bit 2 chooses first or second transition as first capture.
// - Bits 5,1,0 divide cpu clock by 4 to 128; master only.
// - Rate codes 100,000,001,110,010,011 give /4,/8,/16,/32,/64,/128.
// - Done set at end; status access then data access clears; blocks writes.
// - Fault set on low select in master; status read then control write clears.
// - Overrun set when byte completes with done still set; status read clears.
// - Software select mode uses the software level as internal select.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "spcl_defs.svh"
module spcl_top
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output spcl_pkg::spcl_resp_type      s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output spcl_pkg::spcl_resp_type      s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    sck_i,
  output logic                         sck_o,
  output logic                         sck_oe,
  input  wire logic                    mosi_i,
  output logic                         mosi_o,
  output logic                         mosi_oe,
  input  wire logic                    miso_i,
  output logic                         miso_o,
  output logic                         miso_oe,
  input  wire logic                    ss_n_i,
  input  wire logic                    halt_i,
  input  wire logic                    cpu_imask_i,
  output logic                         irq_o,
  output logic                         wake_wait_o,
  output logic                         wake_halt_o
);
  import spcl_pkg::*;

  spcl_state_type state_r;
  spcl_sel_type   wr_sel;
  spcl_sel_type   rd_sel;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic        aw_hold_r, w_hold_r, wstrb0_r;
  logic [11:0] awaddr_r;
  logic [7:0]  wdata_r;
  logic [31:0] rdata_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [7:0]  ctrl_r, buf_r, sh_r;
  logic        done_flag_r, write_clash_flag_r, ovr_r, fault_r, sod_r, ssm_r, ssi_r;
  logic        done_arm_r, write_clash_flag_arm_r, fault_arm_r;
  logic        out_r, sck_r, sck_prev_r;
  logic [4:0]  cnt_r;
  logic        halt_d_r, halt_ok_r;
  logic        sck_oe_r, mosi_oe_r, miso_oe_r, irq_r, wake_wait_r, wake_halt_r;
  logic        wr_do, rd_do, ctrl_wr, stat_wr, data_wr, data_rd, stat_rd, data_acc;
  logic        ie, pe, ms, pol, pha, ss_int, slave_act, m_busy, busy, run;
  logic        tick, m_tick, s_edge, edge_go, capture, done, rx_bit;
  logic        wr_blocked, load, write_clash_flag_set, done_clr, ovr_set, fault, any_flag;
  logic [4:0]  edge_nxt;

  // ==========================================================
  // Address decode, shared by both bus directions
  function automatic spcl_sel_type reg_sel(input logic [11:0] a);
    spcl_sel_type s;
    s = SPCL_SEL_NONE;
    if (a == {2'b00, `SPCL_IDX_DATA, 2'b00})
      s = SPCL_SEL_DATA;
    else if (a == {2'b00, `SPCL_IDX_CTRL, 2'b00})
      s = SPCL_SEL_CTRL;
    else if (a == {2'b00, `SPCL_IDX_STAT, 2'b00})
      s = SPCL_SEL_STAT;
    return s;
  endfunction

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `SPCL_RESP_OKAY;
      awaddr_r  <= 12'h000;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (!aw_hold_r && !bvalid_r)
        awready_r <= 1'b1;
      if (s_axi_wvalid && wready_r)
      begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      else if (!w_hold_r && !bvalid_r)
        wready_r <= 1'b1;
      if (wr_do)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wr_sel == SPCL_SEL_NONE) ? `SPCL_RESP_ERR : `SPCL_RESP_OKAY;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `SPCL_RESP_OKAY;
    end
    else if (rd_do)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= (rd_sel == SPCL_SEL_NONE) ? `SPCL_RESP_ERR : `SPCL_RESP_OKAY;
      unique case (rd_sel)
        SPCL_SEL_DATA: rdata_r <= {24'h000000, buf_r};
        SPCL_SEL_CTRL: rdata_r <= {24'h000000, ctrl_r};
        SPCL_SEL_STAT: rdata_r <= {24'h000000, done_flag_r, write_clash_flag_r, ovr_r, fault_r,
                                   1'b0, sod_r, ssm_r, ssi_r};
        SPCL_SEL_NONE: rdata_r <= 32'h0000_0000;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
    else if (!rvalid_r)
      arready_r <= 1'b1;
  end

  assign wr_sel   = reg_sel(awaddr_r);
  assign rd_sel   = reg_sel(s_axi_araddr);
  assign wr_do    = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_do    = s_axi_arvalid && arready_r;
  assign ctrl_wr  = wr_do && wstrb0_r && (wr_sel == SPCL_SEL_CTRL);
  assign stat_wr  = wr_do && wstrb0_r && (wr_sel == SPCL_SEL_STAT);
  assign data_wr  = wr_do && wstrb0_r && (wr_sel == SPCL_SEL_DATA);
  assign data_rd  = rd_do && (rd_sel == SPCL_SEL_DATA);
  assign stat_rd  = rd_do && (rd_sel == SPCL_SEL_STAT);
  assign data_acc = data_wr || data_rd;

  // ==========================================================
  // Mode decode and serial engine strobes
  assign ie        = ctrl_r[`SPCL_CTRL_IE];
  assign pe        = ctrl_r[`SPCL_CTRL_PE];
  assign ms        = ctrl_r[`SPCL_CTRL_MS];
  assign pol       = ctrl_r[`SPCL_CTRL_POL];
  assign pha       = ctrl_r[`SPCL_CTRL_PHA];
  assign ss_int    = ssm_r ? ssi_r : ss_n_i;
  assign slave_act = pe && !ms && !ss_int;
  assign m_busy    = (state_r == SPCL_XFER) && ms;
  assign busy      = m_busy || (cnt_r != 5'h00);
  // Halt freezes all but a slave that was selected at halt entry
  assign run       = !halt_i || (halt_d_r && halt_ok_r && slave_act);
  assign m_tick    = m_busy && tick;
  assign s_edge    = slave_act && (sck_i != sck_prev_r);
  assign edge_go   = run && (m_tick || s_edge);
  assign edge_nxt  = cnt_r + 5'h01;
  assign capture   = edge_nxt[0] ^ pha;
  assign done      = edge_go && (edge_nxt == `SPCL_EDGES);
  assign rx_bit    = ms ? miso_i : mosi_i;
  assign fault     = run && ms && !ss_int;
  assign wr_blocked = done_flag_r && !done_arm_r;
  assign load      = run && data_wr && !wr_blocked && !busy;
  assign write_clash_flag_set  = run && data_wr && !wr_blocked && busy;
  assign done_clr  = done_arm_r && data_acc;
  assign ovr_set   = done && done_flag_r && !done_clr;
  assign any_flag  = done_flag_r || fault_r || ovr_r;

  spcl_rate_div u_rate
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run && m_busy),
    .restart (!m_busy),
    .sel     ({ctrl_r[`SPCL_CTRL_D2], ctrl_r[1:0]}),
    .tick    (tick)
  );

  // ==========================================================
  // Control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= `SPCL_CTRL_RESET;
    else if (fault)
    begin
      ctrl_r[`SPCL_CTRL_PE] <= 1'b0;
      ctrl_r[`SPCL_CTRL_MS] <= 1'b0;
    end
    else if (ctrl_wr && run)
    begin
      ctrl_r <= wdata_r;
      // Enable and master cannot be raised while a fault is pending
      if (fault_r && !fault_arm_r)
      begin
        ctrl_r[`SPCL_CTRL_PE] <= wdata_r[`SPCL_CTRL_PE] && pe;
        ctrl_r[`SPCL_CTRL_MS] <= wdata_r[`SPCL_CTRL_MS] && ms;
      end
    end
  end

  // ==========================================================
  // Status bits; hardware set wins over software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {done_flag_r, write_clash_flag_r, ovr_r, fault_r} <= 4'h0;
      {done_arm_r, write_clash_flag_arm_r, fault_arm_r} <= 3'h0;
      {sod_r, ssm_r, ssi_r} <= 3'(`SPCL_STAT_RESET);
      buf_r <= 8'h00;
    end
    else if (run)
    begin
      done_flag_r <= done || (done_flag_r && !done_clr);
      ovr_r       <= ovr_set || (ovr_r && !stat_rd);
      fault_r     <= fault || (fault_r && !(fault_arm_r && ctrl_wr));
      write_clash_flag_r      <= write_clash_flag_set || (write_clash_flag_r && !(write_clash_flag_arm_r && data_acc));
      done_arm_r  <= done_flag_r && !done_clr && (done_arm_r || stat_rd || stat_wr);
      write_clash_flag_arm_r  <= write_clash_flag_r && !data_acc && (write_clash_flag_arm_r || stat_rd);
      fault_arm_r <= fault_r && !ctrl_wr && (fault_arm_r || stat_rd);
      // Buffer keeps the first byte after the last clear on overrun
      if (done && !ovr_set)
        buf_r <= capture ? {sh_r[6:0], rx_bit} : sh_r;
      if (stat_wr)
      begin
        sod_r <= wdata_r[`SPCL_STAT_SOD];
        ssm_r <= wdata_r[`SPCL_STAT_SSM];
        ssi_r <= wdata_r[`SPCL_STAT_SSI];
      end
    end
  end

  // ==========================================================
  // Shift engine, shared by master and slave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r    <= SPCL_IDLE;
      sh_r       <= 8'h00;
      out_r      <= 1'b0;
      cnt_r      <= 5'h00;
      sck_prev_r <= 1'b0;
    end
    else if (run)
    begin
      sck_prev_r <= sck_i;
      if (load)
      begin
        sh_r  <= wdata_r;
        out_r <= wdata_r[7];
        if (ms)
          state_r <= SPCL_XFER;
      end
      else if (edge_go)
      begin
        cnt_r <= done ? 5'h00 : edge_nxt;
        if (capture)
          sh_r <= {sh_r[6:0], rx_bit};
        else
          out_r <= sh_r[7];
        if (done)
          state_r <= SPCL_IDLE;
      end
      else if (!m_busy && !slave_act)
      begin
        // Deselect between bytes restarts the slave bit count
        cnt_r   <= 5'h00;
        state_r <= SPCL_IDLE;
      end
    end
  end

  // ==========================================================
  // Serial clock out, idle level from polarity
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sck_r <= 1'b0;
    else if (run && m_busy && edge_go)
      sck_r <= ~sck_r;
    else if (!m_busy)
      sck_r <= pol;
  end

  // ==========================================================
  // Halt entry select capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_d_r  <= 1'b0;
      halt_ok_r <= 1'b0;
    end
    else
    begin
      halt_d_r <= halt_i;
      if (halt_i && !halt_d_r)
        halt_ok_r <= !ss_int;
    end
  end

  // ==========================================================
  // Pin enables and interrupt outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {sck_oe_r, mosi_oe_r, miso_oe_r} <= 3'h0;
      {irq_r, wake_wait_r, wake_halt_r} <= 3'h0;
    end
    else
    begin
      sck_oe_r    <= pe && ms;
      mosi_oe_r   <= pe && ms && !sod_r;
      miso_oe_r   <= pe && !ms && !ss_int && !sod_r;
      irq_r       <= ie && !cpu_imask_i && any_flag;
      wake_wait_r <= ie && any_flag;
      wake_halt_r <= ie && done_flag_r;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign sck_o         = sck_r;
  assign sck_oe        = sck_oe_r;
  assign mosi_o        = out_r;
  assign mosi_oe       = mosi_oe_r;
  assign miso_o        = out_r;
  assign miso_oe       = miso_oe_r;
  assign irq_o         = irq_r;
  assign wake_wait_o   = wake_wait_r;
  assign wake_halt_o   = wake_halt_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_irq_gate_on: assert property (ie && !cpu_imask_i && any_flag |=> irq_o)
    else $error("interrupt not raised");
  a_irq_gate_off: assert property (!ie |=> !irq_o)
    else $error("interrupt raised while disabled");
  a_halt_wake_src: assert property (wake_halt_o |-> $past(done_flag_r))
    else $error("halt wake without done");
  a_wait_wake_src: assert property (ie && (fault_r || ovr_r) |=> wake_wait_o)
    else $error("wait wake missing");
  a_fault_drops_pe: assert property (fault |=> !pe && !ms && fault_r)
    else $error("fault did not clear enable and master");
  a_ovr_second_byte: assert property (ovr_set |=> ovr_r && $stable(buf_r))
    else $error("overrun not flagged or buffer changed");
  a_done_eighth_bit: assert property (done |=> done_flag_r && cnt_r == 5'h00)
    else $error("done not set at byte end");
  a_halt_frozen: assert property (!run |=> $stable(sh_r) && $stable(ctrl_r))
    else $error("state moved during halt");
  a_write_blocked: assert property (data_wr && wr_blocked && !busy
                                    |=> $stable(sh_r))
    else $error("data write not blocked");
  a_echo_byte: assert property (done && !ovr_set |=> buf_r == sh_r)
    else $error("received byte not kept for echo");
  a_idle_level: assert property (!m_busy ##1 !m_busy |-> sck_o == $past(pol))
    else $error("clock idle level wrong");

  c_master_done: cover property (m_busy && done);
  c_slave_done: cover property (slave_act && done);
  c_overrun: cover property (ovr_set);
  c_fault: cover property (fault);
  c_halt_wake: cover property (halt_i && wake_halt_o);
endmodule
